//--- hw/spi_status_monitor.sv
// Function
// (RULE1) Disable forces all flags to reset values
// (RULE2) Transmit-empty reads 0 when full or disabled
// (RULE3) Data register write clears transmit-empty
// (RULE4) Error flags cleared by writing one
// (RULE5) Underrun sets flag, held until cleared
// (RULE6) Multi-master collision sets collision flag
// (RULE7) Slave select loss mid-character sets abort
// (RULE8) Slave clock monitor timeout sets abort
// (RULE9) Receive overrun sets overrun flag
// (RULE10) Receive-full set by data, cleared by read
// (RULE11) Transfer flag high while transfer runs
// (RULE12) Select view is pin XOR polarity
// (RULE13) State bit 7 shows clock pin
// (RULE14) State bit 6 shows data input pin
// (RULE15) State bits 5:0 show machine state
// (RULE16) Pre-transfer states use fixed codes
// (RULE17) Idle zero; bit phases prefix 10
// (RULE18) Polarity bit chooses select active level
// (RULE19) Length code 000 means eight bits
// (RULE20) Hardware set wins over software clear
`default_nettype none
module spi_status_monitor #(
    parameter int unsigned SCK_HALF_CYC    = 4,
    parameter int unsigned SCK_TIMEOUT_CYC = 1024
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic [23:0] addr_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    output logic      [7:0]  rd_data_out,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe_out,
    input  wire logic        mosi_in,
    output logic             mosi_out,
    output logic             mosi_oe_out,
    input  wire logic        miso_in,
    output logic             miso_out,
    output logic             miso_oe_out,
    input  wire logic        ss_in
);
    localparam int unsigned DIV_W = $clog2(SCK_HALF_CYC + 1);
    localparam int unsigned MON_W = $clog2(SCK_TIMEOUT_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);
    localparam logic [MON_W-1:0] MON_LAST = MON_W'(SCK_TIMEOUT_CYC - 1);

    if (SCK_HALF_CYC < 1 || SCK_TIMEOUT_CYC < 2) begin : g_chk
        $error("SCK_HALF_CYC must be at least 1 and SCK_TIMEOUT_CYC at least 2");
    end

    // Pin synchronisers
    logic [spi_mon_pkg::PIN_N-1:0] pins_s;
    pin_sync #(
        .WIDTH (spi_mon_pkg::PIN_N)
    ) u_pin_sync (
        .clk_in   (mclk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({ss_in, miso_in, mosi_in, sck_in}),
        .q_out    (pins_s)
    );

    logic sck_s;
    logic ss_s;
    logic sck_d_r;
    logic ss_d_r;
    logic sck_rise;
    logic sck_fall;
    logic ss_edge;
    assign sck_s    = pins_s[spi_mon_pkg::PIN_SCK];
    assign ss_s     = pins_s[spi_mon_pkg::PIN_SS];
    assign sck_rise = sck_s & ~sck_d_r;
    assign sck_fall = ~sck_s & sck_d_r;
    assign ss_edge  = ss_s ^ ss_d_r;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_d_r <= 1'h0;
            ss_d_r  <= 1'h0;
        end else begin
            sck_d_r <= sck_s;
            ss_d_r  <= ss_s;
        end
    end

    // Control register
    logic [7:0] ctrl_r;
    logic       en;
    logic       mst;
    logic       pol;
    logic       brg;
    logic       i2s;
    logic [2:0] len;
    logic [2:0] idx_top;
    logic       sel_act;
    logic       din;
    assign en  = ctrl_r[spi_mon_pkg::CT_EN];
    assign mst = ctrl_r[spi_mon_pkg::CT_MST];
    assign pol = ctrl_r[spi_mon_pkg::CT_POL];
    assign brg = ctrl_r[spi_mon_pkg::CT_BRG];
    assign i2s = ctrl_r[spi_mon_pkg::CT_I2S];
    assign len = ctrl_r[spi_mon_pkg::CT_LEN_LSB +: spi_mon_pkg::LEN_W];
    assign idx_top = (len == spi_mon_pkg::LEN_FULL) ? spi_mon_pkg::IDX_TOP_FULL
                                                    : len - 3'h1;  // RULE19
    assign sel_act = ~(ss_s ^ pol);  // RULE18
    assign din = mst ? pins_s[spi_mon_pkg::PIN_MISO]
                     : pins_s[spi_mon_pkg::PIN_MOSI];  // RULE14

    // Register decode
    logic wr_ctrl;
    logic wr_data;
    logic wr_stat;
    logic rd_data;
    assign wr_ctrl = wr_en_in && (addr_in == spi_mon_pkg::CTRL_ADDR);
    assign wr_data = wr_en_in && (addr_in == spi_mon_pkg::DATA_ADDR);
    assign wr_stat = wr_en_in && (addr_in == spi_mon_pkg::STATUS_ADDR);
    assign rd_data = rd_en_in && (addr_in == spi_mon_pkg::DATA_ADDR);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_r <= spi_mon_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= wr_data_in;
        end
    end

    // Master clock divider and slave clock monitor
    spi_mon_pkg::fsm_state_type state_r;
    spi_mon_pkg::fsm_state_type state_nxt;
    logic [2:0]       idx_r;
    logic [2:0]       idx_nxt;
    logic [DIV_W-1:0] div_r;
    logic [MON_W-1:0] mon_r;
    logic             tick;
    logic             in_bits;
    logic             timeout;
    assign tick    = (div_r == DIV_LAST);
    assign in_bits = (state_r == spi_mon_pkg::S_BTX) || (state_r == spi_mon_pkg::S_BRX);
    assign timeout = (mon_r == MON_LAST);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r <= '0;
        end else if (!en || !mst || state_r == spi_mon_pkg::S_IDLE || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + DIV_W'(1);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mon_r <= '0;
        end else if (!en || mst || !in_bits || sck_rise || sck_fall || timeout) begin
            mon_r <= '0;
        end else begin
            mon_r <= mon_r + MON_W'(1);
        end
    end

    // Transmit and receive holding, shifter and error state
    logic [7:0] tx_hold_r;
    logic       tx_full_r;
    logic [7:0] tx_shift_r;
    logic       shift_empty_r;
    logic [7:0] rx_shift_r;
    logic [7:0] rx_hold_r;
    logic       rx_full_r;
    logic [3:0] err_r;

    // Bit engine
    logic load;
    logic shift_out;
    logic sample;
    logic done;
    logic tx_underrun_flag_set;
    logic col_set;
    logic abt_set;
    logic rx_overrun_flag_set;
    logic abort_cond;
    assign abort_cond = !mst && !i2s && !sel_act;

    always_comb begin
        state_nxt = state_r;
        idx_nxt   = idx_r;
        load      = 1'h0;
        shift_out = 1'h0;
        sample    = 1'h0;
        done      = 1'h0;
        tx_underrun_flag_set  = 1'h0;
        col_set   = 1'h0;
        abt_set   = 1'h0;
        if (!en) begin
            state_nxt = spi_mon_pkg::S_IDLE;
        end else if (mst && sel_act) begin
            col_set   = 1'h1;  // RULE6
            state_nxt = spi_mon_pkg::S_IDLE;
        end else if (!mst && brg && timeout) begin
            abt_set   = 1'h1;  // RULE8
            state_nxt = spi_mon_pkg::S_IDLE;
        end else begin
            case (state_r)
                spi_mon_pkg::S_IDLE: begin
                    if (mst) begin
                        if (tx_full_r) begin
                            state_nxt = i2s ? spi_mon_pkg::S_IMD1 : spi_mon_pkg::S_MDLY;
                        end
                    end else if (i2s) begin
                        if (ss_edge) begin
                            state_nxt = spi_mon_pkg::S_ISD1;
                            load      = 1'h1;
                        end
                    end else if (sel_act) begin
                        state_nxt = spi_mon_pkg::S_SWAIT;
                        load      = 1'h1;
                    end
                end
                spi_mon_pkg::S_MDLY, spi_mon_pkg::S_IMD2: begin
                    if (tick) begin
                        state_nxt = spi_mon_pkg::S_BTX;
                        idx_nxt   = idx_top;
                        load      = 1'h1;
                    end
                end
                spi_mon_pkg::S_IMD1: begin
                    if (tick) begin
                        state_nxt = spi_mon_pkg::S_IMD2;
                    end
                end
                spi_mon_pkg::S_ISD1: begin
                    if (sck_rise) begin
                        state_nxt = spi_mon_pkg::S_ISD2;
                    end
                end
                spi_mon_pkg::S_ISD2: begin
                    if (sck_fall) begin
                        state_nxt = spi_mon_pkg::S_BTX;
                        idx_nxt   = idx_top;
                        tx_underrun_flag_set  = shift_empty_r;  // RULE5
                    end
                end
                spi_mon_pkg::S_SWAIT: begin
                    if (!sel_act) begin
                        state_nxt = spi_mon_pkg::S_IDLE;
                    end else if (sck_rise) begin
                        state_nxt = spi_mon_pkg::S_BRX;
                        idx_nxt   = idx_top;
                        sample    = 1'h1;
                        tx_underrun_flag_set  = shift_empty_r;  // RULE5
                    end
                end
                spi_mon_pkg::S_BTX: begin
                    if (abort_cond) begin
                        abt_set   = 1'h1;  // RULE7
                        state_nxt = spi_mon_pkg::S_IDLE;
                    end else if (mst ? tick : sck_rise) begin
                        state_nxt = spi_mon_pkg::S_BRX;
                        sample    = 1'h1;
                    end
                end
                spi_mon_pkg::S_BRX: begin
                    if (abort_cond) begin
                        abt_set   = 1'h1;  // RULE7
                        state_nxt = spi_mon_pkg::S_IDLE;
                    end else if (mst ? tick : sck_fall) begin
                        if (idx_r == 3'h0) begin
                            done = 1'h1;
                            if (mst || i2s) begin
                                state_nxt = spi_mon_pkg::S_IDLE;
                            end else begin
                                state_nxt = spi_mon_pkg::S_SWAIT;
                                load      = 1'h1;
                            end
                        end else begin
                            state_nxt = spi_mon_pkg::S_BTX;
                            idx_nxt   = idx_r - 3'h1;
                            shift_out = 1'h1;
                        end
                    end
                end
                default: begin
                    state_nxt = spi_mon_pkg::S_IDLE;
                end
            endcase
        end
    end

    assign rx_overrun_flag_set = done && rx_full_r && !rd_data;  // RULE9

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= spi_mon_pkg::S_IDLE;
            idx_r   <= 3'h0;
        end else begin
            state_r <= state_nxt;
            idx_r   <= idx_nxt;
        end
    end

    // Transmit path
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_hold_r <= 8'h00;
            tx_full_r <= 1'h0;
        end else if (!en) begin
            tx_full_r <= 1'h0;  // RULE1
        end else if (wr_data) begin
            tx_hold_r <= wr_data_in;
            tx_full_r <= 1'h1;  // RULE3
        end else if (load) begin
            tx_full_r <= 1'h0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_shift_r    <= 8'h00;
            shift_empty_r <= 1'h0;
        end else if (load) begin
            tx_shift_r    <= tx_full_r ? tx_hold_r : 8'h00;
            shift_empty_r <= !tx_full_r;
        end
    end

    // Receive path
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_shift_r <= 8'h00;
        end else if (sample) begin
            rx_shift_r[idx_nxt] <= din;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_hold_r <= 8'h00;
            rx_full_r <= 1'h0;
        end else if (!en) begin
            rx_full_r <= 1'h0;  // RULE1
        end else if (done && !rx_overrun_flag_set) begin
            rx_hold_r <= rx_shift_r;
            rx_full_r <= 1'h1;  // RULE10 RULE20
        end else if (rd_data) begin
            rx_full_r <= 1'h0;  // RULE10
        end
    end

    // Error flags: underrun, collision, abort, overrun
    logic [3:0] err_set;
    logic [3:0] err_clr;
    assign err_set = {tx_underrun_flag_set, col_set, abt_set, rx_overrun_flag_set};
    assign err_clr = wr_stat ? wr_data_in[spi_mon_pkg::ST_RX_OVERRUN_FLAG +: 4] : 4'h0;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_r <= 4'h0;
        end else if (!en) begin
            err_r <= 4'h0;  // RULE1
        end else begin
            err_r <= (err_r & ~err_clr) | err_set;  // RULE4 RULE5 RULE20
        end
    end

    // Readable views
    logic [7:0] status_word;
    logic [7:0] state_word;
    logic [5:0] code;
    logic       active;
    assign active = en && (state_r != spi_mon_pkg::S_IDLE)
                       && (state_r != spi_mon_pkg::S_SWAIT);  // RULE11

    always_comb begin
        case (state_r)  // RULE15 RULE16 RULE17
            spi_mon_pkg::S_IDLE:  code = spi_mon_pkg::CODE_IDLE;
            spi_mon_pkg::S_SWAIT: code = spi_mon_pkg::CODE_SWAIT;
            spi_mon_pkg::S_ISD1:  code = spi_mon_pkg::CODE_ISD1;
            spi_mon_pkg::S_ISD2:  code = spi_mon_pkg::CODE_ISD2;
            spi_mon_pkg::S_MDLY:  code = spi_mon_pkg::CODE_MDLY;
            spi_mon_pkg::S_IMD1:  code = spi_mon_pkg::CODE_IMD1;
            spi_mon_pkg::S_IMD2:  code = spi_mon_pkg::CODE_IMD2;
            spi_mon_pkg::S_BTX:   code = {spi_mon_pkg::CODE_BIT_PFX, idx_r, spi_mon_pkg::CODE_TX};
            spi_mon_pkg::S_BRX:   code = {spi_mon_pkg::CODE_BIT_PFX, idx_r, spi_mon_pkg::CODE_RX};
            default:              code = spi_mon_pkg::CODE_IDLE;
        endcase
    end

    assign status_word = {en && !tx_full_r,  // RULE2
                          err_r & {4{en}},
                          rx_full_r && en,
                          active,
                          en ? (ss_s ^ pol) : spi_mon_pkg::STATUS_RESET[0]};  // RULE12 RULE1
    assign state_word  = {sck_s, din, code};  // RULE13 RULE14

    // Read port and pin outputs
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 8'h00;
        end else if (!rd_en_in) begin
            rd_data_out <= 8'h00;
        end else begin
            case (addr_in)
                spi_mon_pkg::STATUS_ADDR: rd_data_out <= status_word;
                spi_mon_pkg::STATE_ADDR:  rd_data_out <= state_word;
                spi_mon_pkg::DATA_ADDR:   rd_data_out <= rx_hold_r;
                spi_mon_pkg::CTRL_ADDR:   rd_data_out <= ctrl_r;
                default:                  rd_data_out <= 8'h00;
            endcase
        end
    end

    logic dout_r;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dout_r <= 1'h0;
        end else if (load) begin
            dout_r <= tx_full_r ? tx_hold_r[idx_top] : 1'h0;
        end else if (shift_out) begin
            dout_r <= tx_shift_r[idx_nxt];
        end
    end
    assign mosi_out = dout_r;
    assign miso_out = dout_r;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_out     <= 1'h0;
            sck_oe_out  <= 1'h0;
            mosi_oe_out <= 1'h0;
            miso_oe_out <= 1'h0;
        end else begin
            sck_out     <= mst && (state_nxt == spi_mon_pkg::S_BRX);
            sck_oe_out  <= en && mst;
            mosi_oe_out <= en && mst;
            miso_oe_out <= en && !mst && sel_act;
        end
    end

    // Checks
    disable_flags_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // RULE1
        !en |-> status_word == spi_mon_pkg::STATUS_RESET)
        else $error("status not at reset value while disabled");
    txe_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // RULE3
        (wr_data && en && $past(en)) |=> !status_word[spi_mon_pkg::ST_TXE] || !en)
        else $error("data write did not clear transmit-empty");
    w1c_clear_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // RULE4
        (wr_stat && wr_data_in[spi_mon_pkg::ST_TX_UNDERRUN_FLAG] && !tx_underrun_flag_set) |=> !err_r[3])
        else $error("underrun flag not cleared by write of one");
    w1c_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // RULE4
        (en && err_r[1] && !(wr_stat && wr_data_in[spi_mon_pkg::ST_ABT])) ##1 en
        |-> err_r[1])
        else $error("abort flag lost without clear");
    set_wins_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // RULE20
        (col_set && en) |=> err_r[2])
        else $error("collision set lost against clear");
    abort_sel_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // RULE7
        (en && in_bits && abort_cond && !(brg && timeout))
        |=> err_r[1] && state_r == spi_mon_pkg::S_IDLE)
        else $error("select loss mid-character did not abort");
    rx_read_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // RULE10
        (rd_data && !done) |=> !rx_full_r)
        else $error("receive-full not cleared by data read");
    active_bits_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // RULE11
        (en && in_bits) |-> status_word[spi_mon_pkg::ST_ACT])
        else $error("transfer flag low during bit phases");
    sel_view_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // RULE12
        (rd_en_in && addr_in == spi_mon_pkg::STATUS_ADDR && en && $stable(ss_s) && $stable(en))
        |=> rd_data_out[spi_mon_pkg::ST_SEL] == $past(ss_s ^ pol))
        else $error("select view mismatch");
    code_bits_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // RULE17
        (state_r == spi_mon_pkg::S_BRX) |-> code == {2'h2, idx_r, 1'h0})
        else $error("bit receive code wrong");
    sck_read_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // RULE13
        (rd_en_in && addr_in == spi_mon_pkg::STATE_ADDR)
        |=> rd_data_out[spi_mon_pkg::SR_SCK] == $past(sck_s))
        else $error("clock pin level not shown");

    master_done_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in) done && mst);
    slave_done_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in) done && !mst);
    timeout_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in) abt_set && timeout);
    overrun_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in) rx_overrun_flag_set);
endmodule
`default_nettype wire

//--- inc/spi_mon_pkg.sv
`default_nettype none
package spi_mon_pkg;
    // Register bus geometry
    localparam int unsigned ADDR_W       = 24;
    localparam int unsigned DATA_W       = 8;
    localparam logic [23:0] DATA_ADDR    = 24'hFFE260;
    localparam logic [23:0] CTRL_ADDR    = 24'hFFE261;
    localparam logic [23:0] STATUS_ADDR  = 24'hFFE264;
    localparam logic [23:0] STATE_ADDR   = 24'hFFE265;

    // Status register fields
    localparam int unsigned ST_TXE       = 7;
    localparam int unsigned ST_TX_UNDERRUN_FLAG      = 6;
    localparam int unsigned ST_COL       = 5;
    localparam int unsigned ST_ABT       = 4;
    localparam int unsigned ST_RX_OVERRUN_FLAG      = 3;
    localparam int unsigned ST_RXF       = 2;
    localparam int unsigned ST_ACT       = 1;
    localparam int unsigned ST_SEL       = 0;
    localparam logic [7:0]  STATUS_RESET = 8'h01;

    // Control register fields
    localparam int unsigned CT_EN        = 0;
    localparam int unsigned CT_MST       = 1;
    localparam int unsigned CT_POL       = 2;
    localparam int unsigned CT_BRG       = 3;
    localparam int unsigned CT_I2S       = 4;
    localparam int unsigned CT_LEN_LSB   = 5;
    localparam int unsigned LEN_W        = 3;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [2:0]  LEN_FULL     = 3'h0;
    localparam logic [2:0]  IDX_TOP_FULL = 3'h7;

    // State register fields
    localparam int unsigned SR_SCK       = 7;
    localparam int unsigned SR_DIN       = 6;

    // Synchroniser lanes
    localparam int unsigned PIN_SCK      = 0;
    localparam int unsigned PIN_MOSI     = 1;
    localparam int unsigned PIN_MISO     = 2;
    localparam int unsigned PIN_SS       = 3;
    localparam int unsigned PIN_N        = 4;

    // Observable state codes
    localparam logic [5:0]  CODE_IDLE    = 6'h00;
    localparam logic [5:0]  CODE_SWAIT   = 6'h01;
    localparam logic [5:0]  CODE_ISD1    = 6'h02;
    localparam logic [5:0]  CODE_ISD2    = 6'h03;
    localparam logic [5:0]  CODE_MDLY    = 6'h10;
    localparam logic [5:0]  CODE_IMD1    = 6'h31;
    localparam logic [5:0]  CODE_IMD2    = 6'h32;
    localparam logic [1:0]  CODE_BIT_PFX = 2'h2;
    localparam logic        CODE_RX      = 1'h0;
    localparam logic        CODE_TX      = 1'h1;

    typedef enum logic [8:0] {
        S_IDLE  = 9'h001,
        S_SWAIT = 9'h002,
        S_ISD1  = 9'h004,
        S_ISD2  = 9'h008,
        S_MDLY  = 9'h010,
        S_IMD1  = 9'h020,
        S_IMD2  = 9'h040,
        S_BTX   = 9'h080,
        S_BRX   = 9'h100
    } fsm_state_type;
endpackage
`default_nettype wire

//--- hw/pin_sync.sv
`default_nettype none
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            q_out  <= '0;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule
`default_nettype wire

//--- dv/spi_partner.sv
`default_nettype none
module spi_partner (
    input  wire logic       sck_in,
    input  wire logic       sel_in,
    input  wire logic       mosi_in,
    input  wire logic [7:0] tx_in,
    output logic            miso_out,
    output logic      [7:0] rx_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh = 8'h00;
    // Reply loaded on select, MSB first, changed on falling clock
    always @(posedge sel_in) sh = tx_in;
    always @(negedge sck_in) if (sel_in) sh = {sh[6:0], ~sh[7]};
    always @(posedge sck_in) if (sel_in) rx_out = {rx_out[6:0], mosi_in};
    // Released line shows the inverse, never a stale bit
    assign miso_out = sel_in ? sh[7] : ~sh[7];
endmodule
`default_nettype wire

//--- dv/spi_status_monitor_tb.sv
`default_nettype none
module spi_status_monitor_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk_in = 0, rst_n_in = 0, wr_en_in = 0, rd_en_in = 0, ss_in = 1;
    logic [23:0] addr_in = 24'h000000;
    logic [7:0]  wr_data_in = 8'h00, rd_data_out, rv, prx, ptx = 8'h3C;
    logic        sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, pmiso;
    logic        sck_drv = 0, mosi_drv = 0, psel = 0;
    wire logic   sck_in = sck_oe_out ? sck_out : sck_drv;
    wire logic   mosi_in = mosi_oe_out ? mosi_out : mosi_drv;
    wire logic   miso_in = miso_oe_out ? miso_out : pmiso;
    int          mismatches = 0, compares = 0;
    always #4 mclk_in = ~mclk_in;
    spi_status_monitor spi_status_monitor_inst (.mclk_in, .rst_n_in, .addr_in, .wr_data_in,
        .wr_en_in, .rd_en_in, .rd_data_out, .sck_in, .sck_out, .sck_oe_out, .mosi_in,
        .mosi_out, .mosi_oe_out, .miso_in, .miso_out, .miso_oe_out, .ss_in);
    spi_partner spi_partner_inst (.sck_in, .sel_in(psel), .mosi_in, .tx_in(ptx),
        .miso_out(pmiso), .rx_out(prx));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task wr(input logic [23:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in <= a; wr_data_in <= d; wr_en_in <= 1'h1;
        @(posedge mclk_in);
        wr_en_in <= 1'h0;
    endtask
    task rd(input logic [23:0] a);
        @(posedge mclk_in);
        addr_in <= a; rd_en_in <= 1'h1;
        @(posedge mclk_in);
        rd_en_in <= 1'h0;
        @(negedge mclk_in);
        rv = rd_data_out;
        @(posedge mclk_in);
    endtask
    initial begin
        #100us;
        mismatches++;
        end_sim();
    end
    initial begin
        cyc(3);
        rst_n_in <= 1'h1;
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv, 8'h01);
        rd(spi_mon_pkg::STATE_ADDR); chk(rv, 8'h00);
        rd(24'hFFE262); chk(rv, 8'h00);
        wr(spi_mon_pkg::CTRL_ADDR, 8'h01);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv, 8'h81);
        wr(spi_mon_pkg::DATA_ADDR, 8'h5A);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv, 8'h01);
        sck_drv <= 1'h1; mosi_drv <= 1'h1; cyc(5);
        rd(spi_mon_pkg::STATE_ADDR); chk(rv & 8'hC0, 8'hC0);
        sck_drv <= 1'h0; mosi_drv <= 1'h0; cyc(5);
        rd(spi_mon_pkg::STATE_ADDR); chk(rv & 8'hC0, 8'h00);
        wr(spi_mon_pkg::CTRL_ADDR, 8'h00);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv, 8'h01);
        for (int i = 0; i < 4; i++) begin
            ss_in <= i[0];
            wr(spi_mon_pkg::CTRL_ADDR, {5'h00, i[1], 2'h1}); cyc(5);
            rd(spi_mon_pkg::STATUS_ADDR); chk(rv & 8'h01, {7'h00, i[0] ^ i[1]});
        end
        wr(spi_mon_pkg::CTRL_ADDR, 8'h00); ss_in <= 1'h1;
        wr(spi_mon_pkg::CTRL_ADDR, 8'h01); ss_in <= 1'h0; cyc(6);
        repeat (2) begin
            #62.5 sck_drv = 1'h1;
            #62.5 sck_drv = 1'h0;
        end
        cyc(1); ss_in <= 1'h1; cyc(8);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv & 8'h50, 8'h50);
        wr(spi_mon_pkg::STATUS_ADDR, 8'h50);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv & 8'h50, 8'h00);
        wr(spi_mon_pkg::CTRL_ADDR, 8'h00);
        wr(spi_mon_pkg::CTRL_ADDR, 8'h03); psel = 1'h1;
        wr(spi_mon_pkg::DATA_ADDR, 8'hA5); cyc(10);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv & 8'h02, 8'h02);
        cyc(100);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv, 8'h85);
        chk(prx, 8'hA5);
        rd(spi_mon_pkg::DATA_ADDR); chk(rv, 8'h3C);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv, 8'h81);
        ss_in <= 1'h0;
        wr(spi_mon_pkg::DATA_ADDR, 8'h11); cyc(20);
        wr(spi_mon_pkg::STATUS_ADDR, 8'h20);
        ss_in <= 1'h1; cyc(4);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv & 8'h20, 8'h20);
        wr(spi_mon_pkg::STATUS_ADDR, 8'h00);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv & 8'h20, 8'h20);
        wr(spi_mon_pkg::STATUS_ADDR, 8'h20);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv & 8'h20, 8'h00);
        wr(spi_mon_pkg::DATA_ADDR, 8'h22); cyc(160);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv & 8'h0C, 8'h0C);
        wr(spi_mon_pkg::CTRL_ADDR, 8'h00); wr(spi_mon_pkg::CTRL_ADDR, 8'h13);
        wr(spi_mon_pkg::DATA_ADDR, 8'h0F);
        rd(spi_mon_pkg::STATE_ADDR); chk(rv & 8'h3F, 8'h31);
        wr(spi_mon_pkg::CTRL_ADDR, 8'h00); wr(spi_mon_pkg::CTRL_ADDR, 8'h09);
        ss_in <= 1'h0; cyc(6);
        rd(spi_mon_pkg::STATE_ADDR); chk(rv, 8'h01);
        sck_drv <= 1'h1; cyc(6);
        rd(spi_mon_pkg::STATE_ADDR); chk(rv, 8'hAE);
        cyc(1100);
        rd(spi_mon_pkg::STATUS_ADDR); chk(rv & 8'h50, 8'h50);
        end_sim();
    end
endmodule
`default_nettype wire
